/* File: core/xmb_pkg.sv */
// Purpose: types shared by the external memory bus interface
// Assumes: nothing beyond the header
// Notes:   states are one-hot
package xmb_pkg;

    typedef enum logic [5:0] {
        XMB_IDLE  = 6'h01,
        XMB_ADDR  = 6'h02,
        XMB_LATCH = 6'h04,
        XMB_STRB  = 6'h08,
        XMB_END   = 6'h10,
        XMB_RECOV = 6'h20
    } xmb_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        we;
        logic [7:0]  wdata;
        logic        next_ram;
    } xmb_req_t;

    typedef struct packed {
        logic       ack;
        logic       ext;
        logic       miss;
        logic [7:0] rdata;
    } xmb_resp_t;

    typedef struct packed {
        logic [1:0] extra;
        logic       recov;
    } xmb_wait_t;

    typedef struct packed {
        logic [7:0] ad;
        logic [7:0] ad_oe;
        logic [7:0] ad_pu;
        logic [7:0] ad_keep;
        logic [7:0] ha;
        logic [7:0] ha_oe;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic       ctl_ovr;
    } xmb_pins_t;

endpackage

/* File: core/xmb_regs.svh */
// Purpose: register offsets, field positions, reset values and wait counts
// Assumes: offsets are Avalon word indices; byte address is four times the index
// Notes:   definitions only
`ifndef XMB_REGS_SVH
`define XMB_REGS_SVH

`define XMB_IDX_SYS_CTL     3'h0
`define XMB_IDX_EXT_CTL     3'h1
`define XMB_IDX_SPEC_FN     3'h2
`define XMB_IDX_PA_OUT      3'h3
`define XMB_IDX_PA_DIR      3'h4
`define XMB_IDX_PC_OUT      3'h5
`define XMB_IDX_PC_DIR      3'h6
`define XMB_IDX_STATUS      3'h7

`define XMB_REG_RST         8'h00

`define XMB_SYS_EN_BIT      7
`define XMB_SYS_UPW_B6      6
`define XMB_EXT_LIM_MSB     6
`define XMB_EXT_LIM_LSB     4
`define XMB_EXT_LOW_HI_BIT  3
`define XMB_EXT_LOW_LO_BIT  2
`define XMB_EXT_UPW_B1      1
`define XMB_SFR_KEEP_BIT    6
`define XMB_SFR_HM_MSB      5
`define XMB_SFR_HM_LSB      3

`define XMB_INT_LIMIT       16'h0260
`define XMB_HM_ALL          3'h7

// Strobe length is this count plus one cycle
`define XMB_EXTRA_W00       2'h0
`define XMB_EXTRA_W01       2'h1
`define XMB_EXTRA_W10       2'h2
`define XMB_EXTRA_W11       2'h2

`endif

/* File: core/xmb_top.sv */
// Purpose: external data memory bus with address latch strobe and read/write strobes
// Assumes: requester holds req_valid_i until resp_o.ack, drops it next cycle
// Notes:   registers reached over Avalon-MM, one word per register
//
// Contract
// - While enabled, the interface drives its pins regardless of port direction settings.
// - Each access is classified internal or external; only external ones strobe.
// - Low address byte is valid on the shared lines when the latch strobe falls.
// - Latch strobe stays low through the whole data transfer.
// - Internal accesses may show address activity but never assert read or write strobes.
// - Disabled interface gives pins back; high addresses never alias internal memory.
// - Pull-up on a shared line follows its port output bit set to one.
// - With keeper on, tri-stated shared lines hold their last driven value.
// - Four software-chosen wait settings exist for external accesses.
// - External space splits into lower and upper sectors with own wait settings.
// - Each sector's wait setting is a two-bit code from its select bits.
// - After the last period, an extra latch pulse appears only if next access hits RAM.
// - Enable bit 7 switches pins to memory use; zero restores port use.
// - Upper wait select bit sits at bit 6 of the system control register.
// - Extended control: limit at bits 6..4, lower wait 3..2, upper wait bit 1.
// - Limit zero treats all external space as one upper sector.
// - Nonzero limit k puts the sector boundary at k times 0x2000.
// - Codes give 0, 1, 2 strobe waits, or 2 waits plus one recovery cycle.
// - Keeper follows its own enable bit even when the interface is off.
// - High-address mask releases high pins from the top; code 7 releases all.
`timescale 1ns/1ps
`default_nettype none
`include "xmb_regs.svh"

module xmb_top (
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic [2:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic [31:0]              avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire logic                req_valid_i,
    input  wire xmb_pkg::xmb_req_t   req_i,
    input  wire logic [7:0]          ad_i,
    output xmb_pkg::xmb_pins_t       pins_o,
    output xmb_pkg::xmb_resp_t       resp_o
);
    import xmb_pkg::*;

    logic [7:0]  sys_q;
    logic [7:0]  ext_q;
    logic [7:0]  sfr_q;
    logic [7:0]  pa_out_q;
    logic [7:0]  pa_dir_q;
    logic [7:0]  pc_out_q;
    logic [7:0]  pc_dir_q;
    logic        waitreq_q;
    logic [31:0] rdata_q;
    xmb_state_t  state_q;
    xmb_state_t  state_d;
    xmb_req_t    cur_q;
    logic        int_q;
    xmb_wait_t   wt_q;
    xmb_wait_t   wsel;
    logic [1:0]  cnt_q;
    logic [7:0]  rbuf_q;
    xmb_resp_t   resp_q;
    xmb_pins_t   pins_q;
    xmb_pins_t   pins_d;
    logic        enable;
    logic        keep_en;
    logic [2:0]  hmask;
    logic        is_ext;
    logic        go;
    logic        fin;
    logic        strobe_act;

    assign enable  = sys_q[`XMB_SYS_EN_BIT];
    assign keep_en = sfr_q[`XMB_SFR_KEEP_BIT];
    assign hmask   = sfr_q[`XMB_SFR_HM_MSB:`XMB_SFR_HM_LSB];
    assign is_ext  = req_i.addr >= `XMB_INT_LIMIT;
    assign go      = req_valid_i && !resp_q.ack && state_q == XMB_IDLE;

    // High pins still owned by the interface for a mask code
    function automatic logic [7:0] hi_owned(input logic [2:0] m);
        if (m == `XMB_HM_ALL) begin
            hi_owned = 8'h00;
        end else begin
            hi_owned = 8'hFF >> m;
        end
    endfunction

    xmb_wait_sel u_wait_sel (
        .addr_top_i   (req_i.addr[15:13]),
        .limit_i      (ext_q[`XMB_EXT_LIM_MSB:`XMB_EXT_LIM_LSB]),
        .upper_code_i ({ext_q[`XMB_EXT_UPW_B1], sys_q[`XMB_SYS_UPW_B6]}),
        .lower_code_i ({ext_q[`XMB_EXT_LOW_HI_BIT], ext_q[`XMB_EXT_LOW_LO_BIT]}),
        .wait_o       (wsel)
    );

    // Avalon handshake: one wait cycle, then a single low cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            waitreq_q <= 1'h1;
        end else if ((avs_read_i || avs_write_i) && waitreq_q) begin
            waitreq_q <= 1'h0;
        end else begin
            waitreq_q <= 1'h1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0;
        end else if (avs_read_i && waitreq_q) begin
            case (avs_address_i)
                `XMB_IDX_SYS_CTL: rdata_q <= {24'h0, sys_q};
                `XMB_IDX_EXT_CTL: rdata_q <= {24'h0, ext_q};
                `XMB_IDX_SPEC_FN: rdata_q <= {24'h0, sfr_q};
                `XMB_IDX_PA_OUT:  rdata_q <= {24'h0, pa_out_q};
                `XMB_IDX_PA_DIR:  rdata_q <= {24'h0, pa_dir_q};
                `XMB_IDX_PC_OUT:  rdata_q <= {24'h0, pc_out_q};
                `XMB_IDX_PC_DIR:  rdata_q <= {24'h0, pc_dir_q};
                `XMB_IDX_STATUS:  rdata_q <= {16'h0, rbuf_q, 7'h0, state_q != XMB_IDLE};
                default:          rdata_q <= 32'h0;
            endcase
        end
    end

    // Writes land at the edge that ends the request; status is read-only
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sys_q    <= `XMB_REG_RST;
            ext_q    <= `XMB_REG_RST;
            sfr_q    <= `XMB_REG_RST;
            pa_out_q <= `XMB_REG_RST;
            pa_dir_q <= `XMB_REG_RST;
            pc_out_q <= `XMB_REG_RST;
            pc_dir_q <= `XMB_REG_RST;
        end else if (avs_write_i && !waitreq_q && avs_byteenable_i[0]) begin
            case (avs_address_i)
                `XMB_IDX_SYS_CTL: sys_q    <= avs_writedata_i[7:0];
                `XMB_IDX_EXT_CTL: ext_q    <= avs_writedata_i[7:0];
                `XMB_IDX_SPEC_FN: sfr_q    <= avs_writedata_i[7:0];
                `XMB_IDX_PA_OUT:  pa_out_q <= avs_writedata_i[7:0];
                `XMB_IDX_PA_DIR:  pa_dir_q <= avs_writedata_i[7:0];
                `XMB_IDX_PC_OUT:  pc_out_q <= avs_writedata_i[7:0];
                `XMB_IDX_PC_DIR:  pc_dir_q <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end

    // Access sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            XMB_IDLE: begin
                if (go && enable) begin
                    state_d = XMB_ADDR;
                end
            end
            XMB_ADDR:  state_d = XMB_LATCH;
            XMB_LATCH: state_d = int_q ? XMB_IDLE : XMB_STRB;
            XMB_STRB: begin
                if (cnt_q == 2'h0) begin
                    state_d = XMB_END;
                end
            end
            XMB_END:   state_d = wt_q.recov ? XMB_RECOV : XMB_IDLE;
            XMB_RECOV: state_d = XMB_IDLE;
            default:   state_d = XMB_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= XMB_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cur_q <= '0;
            int_q <= 1'h0;
            wt_q  <= '0;
            cnt_q <= 2'h0;
        end else if (go) begin
            cur_q <= req_i;
            int_q <= !is_ext;
            wt_q  <= wsel;
            cnt_q <= wsel.extra;
        end else if (state_q == XMB_STRB) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end

    // Read data is taken on the edge that lifts the read strobe
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rbuf_q <= 8'h00;
        end else if (state_q == XMB_STRB && cnt_q == 2'h0 && !cur_q.we) begin
            rbuf_q <= ad_i;
        end
    end

    assign fin = (state_q == XMB_LATCH && int_q) || (state_q == XMB_END && !wt_q.recov)
               || state_q == XMB_RECOV || (go && !enable);

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            resp_q <= '0;
        end else begin
            resp_q.ack <= fin;
            if (go && !enable) begin
                // Disabled: external addresses answer as a miss, no wrap onto internal
                resp_q.ext   <= 1'h0;
                resp_q.miss  <= is_ext;
                resp_q.rdata <= 8'h00;
            end else begin
                resp_q.ext   <= fin && !int_q;
                resp_q.miss  <= 1'h0;
                resp_q.rdata <= (fin && !int_q && !cur_q.we) ? rbuf_q : 8'h00;
            end
        end
    end

    // Pins are built from the next state so they leave flip-flops aligned to it
    always_comb begin
        xmb_req_t   src;
        logic       drv_addr;
        logic       strb;
        logic       endp;
        logic [7:0] own;
        logic [7:0] val;
        src      = (state_q == XMB_IDLE) ? req_i : cur_q;
        drv_addr = state_d == XMB_ADDR || state_d == XMB_LATCH;
        strb     = state_d == XMB_STRB;
        endp     = state_d == XMB_END;
        own      = hi_owned(hmask);
        val      = 8'h00;
        pins_d   = pins_q;
        if (enable) begin
            // Direction registers are ignored while the interface owns the pins
            pins_d.ad_oe   = (drv_addr || ((strb || endp) && src.we)) ? 8'hFF : 8'h00;
            val            = drv_addr ? src.addr[7:0] : src.wdata;
            pins_d.ha      = (own & src.addr[15:8]) | (~own & pc_out_q);
            pins_d.ha_oe   = own | pc_dir_q;
            pins_d.ale     = state_d == XMB_ADDR || (endp && src.next_ram);
            pins_d.rd_n    = !(strb && !src.we);
            pins_d.wr_n    = !(strb && src.we);
            pins_d.ctl_ovr = 1'h1;
        end else begin
            pins_d.ad_oe   = pa_dir_q;
            val            = pa_out_q;
            pins_d.ha      = pc_out_q;
            pins_d.ha_oe   = pc_dir_q;
            pins_d.ale     = 1'h0;
            pins_d.rd_n    = 1'h1;
            pins_d.wr_n    = 1'h1;
            pins_d.ctl_ovr = 1'h0;
        end
        // Undriven bits keep their old value so the keeper has something to hold
        pins_d.ad      = (val & pins_d.ad_oe) | (pins_q.ad & ~pins_d.ad_oe);
        pins_d.ad_keep = {8{keep_en}} & ~pins_d.ad_oe;
        pins_d.ad_pu   = pa_out_q & ~pins_d.ad_oe;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pins_q      <= '0;
            pins_q.rd_n <= 1'h1;
            pins_q.wr_n <= 1'h1;
        end else begin
            pins_q <= pins_d;
        end
    end

    assign avs_waitrequest_o = waitreq_q;
    assign avs_readdata_o    = rdata_q;
    assign pins_o            = pins_q;
    assign resp_o            = resp_q;
    assign strobe_act        = !(pins_q.rd_n && pins_q.wr_n);

    property p_override;
        @(posedge clock_i) disable iff (rst_i)
        pins_q.ctl_ovr && state_q == XMB_ADDR |-> pins_q.ad_oe == 8'hFF;
    endproperty
    a_override: assert property (p_override)
        else $error("address phase not driving shared lines");

    property p_int_no_strobe;
        @(posedge clock_i) disable iff (rst_i)
        go && enable && !is_ext |-> !strobe_act[*4];
    endproperty
    a_int_no_strobe: assert property (p_int_no_strobe)
        else $error("strobe during internal access");

    property p_ale_addr;
        @(posedge clock_i) disable iff (rst_i)
        $fell(pins_q.ale) && state_q == XMB_LATCH
            |-> pins_q.ad_oe == 8'hFF && pins_q.ad == cur_q.addr[7:0];
    endproperty
    a_ale_addr: assert property (p_ale_addr)
        else $error("address not valid at latch fall");

    property p_ale_low_xfer;
        @(posedge clock_i) disable iff (rst_i)
        strobe_act |-> !pins_q.ale;
    endproperty
    a_ale_low_xfer: assert property (p_ale_low_xfer)
        else $error("latch strobe high during transfer");

    property p_no_alias;
        @(posedge clock_i) disable iff (rst_i)
        go && !enable && is_ext |=> resp_q.ack && resp_q.miss && state_q == XMB_IDLE;
    endproperty
    a_no_alias: assert property (p_no_alias)
        else $error("disabled external access not answered as miss");

    property p_pullup;
        @(posedge clock_i) disable iff (rst_i)
        ##1 pins_q.ad_pu == ($past(pa_out_q) & ~pins_q.ad_oe);
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up mismatch");

    property p_keeper;
        @(posedge clock_i) disable iff (rst_i)
        ##1 (pins_q.ad_keep & $past(pins_q.ad_keep) & (pins_q.ad ^ $past(pins_q.ad))) == 8'h00;
    endproperty
    a_keeper: assert property (p_keeper)
        else $error("kept line changed value");

    property p_wait0;
        @(posedge clock_i) disable iff (rst_i)
        $rose(strobe_act) && wt_q.extra == `XMB_EXTRA_W00 |=> !strobe_act;
    endproperty
    a_wait0: assert property (p_wait0)
        else $error("no-wait strobe not one cycle");

    property p_wait2;
        @(posedge clock_i) disable iff (rst_i)
        $rose(strobe_act) && wt_q.extra == `XMB_EXTRA_W10 |-> strobe_act[*3] ##1 !strobe_act;
    endproperty
    a_wait2: assert property (p_wait2)
        else $error("two-wait strobe not three cycles");

    property p_recov;
        @(posedge clock_i) disable iff (rst_i)
        $fell(strobe_act) && wt_q.recov |=> state_q == XMB_RECOV ##1 state_q == XMB_IDLE;
    endproperty
    a_recov: assert property (p_recov)
        else $error("recovery cycle missing");

    property p_extra_ale;
        @(posedge clock_i) disable iff (rst_i)
        $fell(strobe_act) && pins_q.ctl_ovr |-> pins_q.ale == cur_q.next_ram;
    endproperty
    a_extra_ale: assert property (p_extra_ale)
        else $error("extra latch pulse wrong");

    property p_rd_float;
        @(posedge clock_i) disable iff (rst_i)
        $rose(pins_q.rd_n) |-> rbuf_q == $past(ad_i) && $past(pins_q.ad_oe) == 8'h00;
    endproperty
    a_rd_float: assert property (p_rd_float)
        else $error("read capture or float wrong");

    property p_keep_free;
        @(posedge clock_i) disable iff (rst_i)
        !keep_en ##1 !keep_en |-> pins_q.ad_keep == 8'h00;
    endproperty
    a_keep_free: assert property (p_keep_free)
        else $error("keeper active while disabled");

endmodule
`default_nettype wire

/* File: core/xmb_wait_sel.sv */
// Purpose: picks the wait setting of the sector that an address falls in
// Assumes: caller passes the top three address bits
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "xmb_regs.svh"

module xmb_wait_sel (
    input  wire logic [2:0]        addr_top_i,
    input  wire logic [2:0]        limit_i,
    input  wire logic [1:0]        upper_code_i,
    input  wire logic [1:0]        lower_code_i,
    output xmb_pkg::xmb_wait_t     wait_o
);
    import xmb_pkg::*;

    logic [1:0] code;

    always_comb begin
        // Zero limit means one sector, timed by the upper code
        if (limit_i == 3'h0 || addr_top_i >= limit_i) begin
            code = upper_code_i;
        end else begin
            code = lower_code_i;
        end
        wait_o.recov = 1'h0;
        case (code)
            2'h0: wait_o.extra = `XMB_EXTRA_W00;
            2'h1: wait_o.extra = `XMB_EXTRA_W01;
            2'h2: wait_o.extra = `XMB_EXTRA_W10;
            2'h3: begin
                wait_o.extra = `XMB_EXTRA_W11;
                wait_o.recov = 1'h1;
            end
            default: wait_o.extra = `XMB_EXTRA_W00;
        endcase
    end

endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the external memory bus block
// Assumes: acc counts edges from the one that takes the request to the one that sees ack
// Notes:   outputs are sampled at the rising edge, before that edge's updates land
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import xmb_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [2:0]  avs_address_i = 3'h0;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        req_valid_i = 1'b0;
    xmb_req_t    req_i = '0;
    logic [7:0]  ad_i;
    xmb_pins_t   pins_o;
    xmb_resp_t   resp_o;
    xmb_resp_t   last_resp;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;

    always #10 clock_i = ~clock_i;

    xmb_top dut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .req_valid_i(req_valid_i), .req_i(req_i),
        .ad_i(ad_i), .pins_o(pins_o), .resp_o(resp_o));
    xmb_sram_model mem (.pins_i(pins_o), .ad_o(ad_i));

    task automatic give_verdict;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic av_wr(input logic [2:0] idx, input logic [7:0] d);
        @(posedge clock_i);
        avs_address_i <= idx;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= 1'b1;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask

    task automatic av_rd(input logic [2:0] idx, output logic [31:0] d);
        @(posedge clock_i);
        avs_address_i <= idx;
        avs_read_i <= 1'b1;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        d = avs_readdata_o;
        avs_read_i <= 1'b0;
    endtask

    // One access; checks latency, strobe length, latch pulses and the byte latched
    task automatic acc(input logic [15:0] a, input logic we, input logic [7:0] wd,
                       input logic nr, input int exp_n, input int exp_strb,
                       input int exp_ale);
        int n;
        int strb;
        int ales;
        logic ale_p;
        n = 0;
        strb = 0;
        ales = 0;
        ale_p = 1'b0;
        repeat (3) @(posedge clock_i);
        req_i <= '{addr: a, we: we, wdata: wd, next_ram: nr};
        req_valid_i <= 1'b1;
        while (n < 40) begin
            @(posedge clock_i);
            n++;
            if (pins_o.rd_n === 1'b0 || pins_o.wr_n === 1'b0) begin
                strb++;
                cmp(pins_o.ale, 1'b0);
            end
            if (pins_o.ale === 1'b1 && ale_p === 1'b0) ales++;
            if (pins_o.ale === 1'b0 && ale_p === 1'b1 && ales == 1) begin
                cmp(pins_o.ad, a[7:0]);
                cmp(pins_o.ha, a[15:8]);
                cmp(pins_o.ad_oe, 8'hFF);
            end
            ale_p = pins_o.ale;
            if (resp_o.ack === 1'b1) break;
        end
        last_resp = resp_o;
        req_valid_i <= 1'b0;
        cmp(n, exp_n);
        cmp(strb, exp_strb);
        cmp(ales, exp_ale);
    endtask

    task automatic t_reset;
        logic [31:0] d;
        for (int i = 0; i < 3; i++) begin
            av_rd(i[2:0], d);
            cmp(d, 32'h0);
        end
        av_wr(3'h1, 8'h76);
        av_rd(3'h1, d);
        cmp(d, 32'h76);
        av_wr(3'h1, 8'h00);
    endtask

    task automatic t_disabled;
        av_wr(3'h4, 8'h0F);
        acc(16'h1000, 1'b0, 8'h00, 1'b0, 2, 0, 0);
        cmp({last_resp.miss, last_resp.ext}, 2'b10);
        cmp(pins_o.ad_oe, 8'h0F);
        cmp(pins_o.ctl_ovr, 1'b0);
    endtask

    task automatic t_internal;
        av_wr(3'h0, 8'h80);
        // Register lands at the last edge of the write, the pins one edge later
        repeat (2) @(posedge clock_i);
        cmp(pins_o.ctl_ovr, 1'b1);
        acc(16'h0100, 1'b0, 8'h00, 1'b0, 4, 0, 1);
        cmp(last_resp.ext, 1'b0);
    endtask

    task automatic t_waits;
        int ex;
        int rc;
        for (int c = 0; c < 4; c++) begin
            ex = (c == 0) ? 0 : (c == 1) ? 1 : 2;
            rc = (c == 3) ? 1 : 0;
            av_wr(3'h0, 8'h80 | (c[0] << 6));
            av_wr(3'h1, c[1] << 1);
            acc(16'h3000 + c, 1'b1, 8'hA0 + c, 1'b0, 6 + ex + rc, ex + 1, 1);
            acc(16'h3000 + c, 1'b0, 8'h00, 1'b0, 6 + ex + rc, ex + 1, 1);
            cmp(last_resp.ext, 1'b1);
            cmp(last_resp.rdata, 8'hA0 + c);
        end
    endtask

    task automatic t_sectors;
        logic [15:0] at [4] = '{16'h1FFF, 16'h2000, 16'hDFFF, 16'hE000};
        logic [2:0]  lim [4] = '{3'h1, 3'h1, 3'h7, 3'h7};
        int          lat [4] = '{7, 6, 7, 6};
        av_wr(3'h0, 8'h80);
        for (int i = 0; i < 4; i++) begin
            av_wr(3'h1, {1'b0, lim[i], 4'h4});
            acc(at[i], 1'b0, 8'h00, 1'b0, lat[i], lat[i] - 5, 1);
        end
    endtask

    task automatic t_ale;
        av_wr(3'h1, 8'h00);
        acc(16'h4000, 1'b1, 8'h3C, 1'b1, 6, 1, 2);
        acc(16'h4000, 1'b0, 8'h00, 1'b0, 6, 1, 1);
        cmp(last_resp.rdata, 8'h3C);
    endtask

    task automatic t_pins;
        av_wr(3'h3, 8'h5A);
        repeat (2) @(posedge clock_i);
        cmp(pins_o.ad_pu, 8'h5A);
        av_wr(3'h2, 8'h18);
        av_wr(3'h6, 8'h00);
        repeat (2) @(posedge clock_i);
        cmp(pins_o.ha_oe, 8'h1F);
        av_wr(3'h0, 8'h00);
        av_wr(3'h2, 8'h40);
        repeat (2) @(posedge clock_i);
        // Port A direction is still 0x0F, so only the upper four lines float
        cmp(pins_o.ad_keep, 8'hF0);
        // Pull-ups off before any low-power phase
        av_wr(3'h3, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        t_reset();
        t_disabled();
        t_internal();
        t_waits();
        t_sectors();
        t_ale();
        t_pins();
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: testbench/xmb_sram_model.sv */
// Purpose: external SRAM behind a transparent address latch
// Assumes: latch is open while ale is high, data is written on the rising edge of wr_n
// Notes:   a released bus shows the inverse of the last value, so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none

module xmb_sram_model (
    input  wire xmb_pkg::xmb_pins_t pins_i,
    output logic [7:0]              ad_o
);
    import xmb_pkg::*;
    logic [7:0]  mem [0:65535];
    logic [7:0]  lat_q;
    logic [7:0]  last_q;
    logic [15:0] wa_q;
    always @* if (pins_i.ale) lat_q = pins_i.ad;
    // Write address is taken as the strobe falls: a trailing latch pulse can open the
    // latch in the same step that lifts the strobe
    always @(negedge pins_i.wr_n) wa_q = {pins_i.ha, lat_q};
    always @(posedge pins_i.wr_n) mem[wa_q] = pins_i.ad;
    always @* begin
        if (!pins_i.rd_n) begin
            ad_o = mem[{pins_i.ha, lat_q}];
            last_q = ad_o;
        end else begin
            ad_o = ~last_q;
        end
    end
    initial begin
        last_q = 8'h00;
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    end
endmodule
`default_nettype wire
